/* rtl/carriage_space_control.sv */
// Carriage line-space sequencing with Wishbone registers
//
// Implementation choices: the Wishbone register port and the register addresses.
`timescale 1ns/10ps
`default_nettype none
`include "csc_defs.svh"

// Contract
// RQ1: Triple space stops on third contact make
// RQ2: Triple releases double stage on contact break
// RQ3: Panel space request overrides internal request
// RQ4: Panel double/triple opens internal single stop
// RQ5: Panel single bypasses internal double stage
// RQ6: Panel triple over internal double counts three
// RQ7: Suppress pulse latches, blocks clutch request
// RQ8: Suppress cancels pending double and triple
// RQ9: Default one space before every print
// RQ10: Spacing starts from start-of-cycle cam window
// RQ11: List on: detail, total single; group double
// RQ12: List off: minor none, others single, double
// RQ13: Detail listing needs list tied all cycles
// RQ14: Spacing at print rate, low carriage speed
// RQ15: Stop drops clutch and clears request latches
// RQ16: Clutch latch sets at cam, drives clutch
// RQ17: Cycle index is clock-driven degree counter
module carriage_space_control #(
   parameter int unsigned DEG_CYC_100 =
      32'(`CSC_CLK_HZ * `CSC_SEC_PER_MIN / (`CSC_RATE_LOW_CPM * `CSC_DEG_PER_REV)),
   parameter int unsigned DEG_CYC_150 =
      32'(`CSC_CLK_HZ * `CSC_SEC_PER_MIN / (`CSC_RATE_HIGH_CPM * `CSC_DEG_PER_REV))
) (
   input  wire logic                clk,            // System clock, 40 MHz
   input  wire logic                sys_rst,        // Synchronous reset
   input  wire logic                wb_cyc_i,       // Bus cycle
   input  wire logic                wb_stb_i,       // Bus strobe
   input  wire logic                wb_we_i,        // Write enable
   input  wire logic [7:0]          wb_adr_i,       // Byte address
   input  wire logic [3:0]          wb_sel_i,       // Byte lanes
   input  wire logic [31:0]         wb_dat_i,       // Write data
   output logic [31:0]              wb_dat_o,       // Read data
   output logic                     wb_ack_o,       // Acknowledge
   input  wire csc_pkg::csc_panel_t panelPulse,     // Panel impulse pins
   input  wire csc_pkg::csc_cycle_t cycleType,      // Cycle-type pins
   input  wire logic                lineContact,    // Line-space contact pin
   output logic                     clutchDrive,    // Carriage clutch magnet
   output logic                     carriageStop,   // Stop relay pulse
   output logic                     lowSpeedSel     // Low carriage speed
);
   import csc_pkg::*;

   // ************************************************************
   // Pin synchronisers
   // ************************************************************
   csc_panel_t panelA_reg;
   csc_panel_t panelB_reg;
   csc_cycle_t cycleA_reg;
   csc_cycle_t cycleB_reg;
   logic       contactA_reg;
   logic       contactB_reg;
   logic       contactC_reg;

   // Two flops per pin, third flop only for edge detection
   always_ff @(posedge clk) begin
      panelA_reg   <= panelPulse;
      panelB_reg   <= panelA_reg;
      cycleA_reg   <= cycleType;
      cycleB_reg   <= cycleA_reg;
      contactA_reg <= lineContact;
      contactB_reg <= contactA_reg;
      contactC_reg <= contactB_reg;
   end

   // ************************************************************
   // Control register and machine-cycle index
   // ************************************************************
   logic [`CSC_CTRL_W-1:0] ctrl_reg;
   logic [`CSC_CTRL_W-1:0] ctrl_next;
   logic [`CSC_DEG_W-1:0]  degree;
   logic                   degTick;
   logic                   listOn;
   logic                   runOn;
   csc_rate_t              rateSel;

   assign listOn  = ctrl_reg[`CSC_CTRL_LIST];
   assign runOn   = ctrl_reg[`CSC_CTRL_RUN];
   assign rateSel = csc_rate_t'(ctrl_reg[`CSC_CTRL_RATE]);

   // Index advanced by the clock at the printing rate
   csc_cycle_index #(
      .DIV_100 (DEG_CYC_100),
      .DIV_150 (DEG_CYC_150)
   ) u_index (
      .clk     (clk),
      .sys_rst (sys_rst),
      .runEn   (runOn),
      .rateSel (rateSel),
      .degree  (degree),
      .degTick (degTick)
   ); // RQ17 RQ14

   // ************************************************************
   // Angle windows and contact edges
   // ************************************************************
   logic camWin;
   logic eacWin;
   logic suppHoldWin;
   logic contactMake;
   logic contactBreak;

   assign camWin       = degree <= `CSC_CAM_END; // RQ10
   assign eacWin       = degree >= `CSC_EAC_START;
   assign suppHoldWin  = eacWin || (degree <= `CSC_SUPP_END);
   assign contactMake  = contactB_reg && !contactC_reg;
   assign contactBreak = !contactB_reg && contactC_reg;

   // ************************************************************
   // Relay latches
   // ************************************************************
   logic clutch_reg;
   logic clutch_next;
   logic suppress_reg;
   logic suppress_next;
   logic panelSingle_reg;
   logic panelSingle_next;
   logic doubleStage_reg;
   logic doubleStage_next;
   logic tripleStage_reg;
   logic tripleStage_next;
   logic doubleHold_reg;
   logic doubleHold_next;
   logic tripleHold_reg;
   logic tripleHold_next;
   logic camDone_reg;
   logic camDone_next;
   logic stop_reg;
   logic lowSpeed_reg;
   logic [`CSC_COUNT_W-1:0] spaces_reg;
   logic [`CSC_COUNT_W-1:0] spaces_next;

   // Internal space demand from the cycle type
   logic intSingle;
   logic intDouble;
   logic panelAny;
   logic anyRequest;
   logic clutchSet;
   logic takeDouble;
   logic firstStep;
   logic secondStep;
   logic stopNow;

   assign intSingle = listOn ? (cycleB_reg.detail || cycleB_reg.minorTotal ||
                                cycleB_reg.interTotal || cycleB_reg.majorTotal)
                             : (cycleB_reg.interTotal || cycleB_reg.majorTotal); // RQ9 RQ11 RQ12 RQ13
   assign intDouble = cycleB_reg.firstCard; // RQ11 RQ12
   assign panelAny  = panelSingle_reg || doubleStage_reg || tripleStage_reg;

   // Clutch request from the cam window when any space is held
   assign anyRequest = panelAny || intSingle || intDouble;
   assign clutchSet  = runOn && camWin && !camDone_reg && !clutch_reg &&
                       !suppress_reg && anyRequest; // RQ16 RQ7 RQ10
   // Internal double is dropped when the panel asked for single or triple
   assign takeDouble = clutchSet && intDouble && !panelSingle_reg && !tripleStage_reg; // RQ3

   // Stage stepping on each contact make
   assign firstStep  = clutch_reg && contactMake && tripleStage_reg && !tripleHold_reg; // RQ1 RQ6
   assign secondStep = clutch_reg && contactMake && !firstStep && doubleStage_reg &&
                       !doubleHold_reg && !panelSingle_reg; // RQ4 RQ5
   assign stopNow    = clutch_reg && contactMake && !firstStep && !secondStep; // RQ1 RQ5

   // Next-state equations of the latches
   assign clutch_next      = (clutch_reg || clutchSet) && !stopNow; // RQ15 RQ16
   assign suppress_next    = (suppress_reg || (panelB_reg.suppress && eacWin)) && suppHoldWin; // RQ7
   assign panelSingle_next = (panelSingle_reg || (panelB_reg.single && eacWin)) && !stopNow; // RQ15
   assign doubleStage_next = (doubleStage_reg || (panelB_reg.dbl && eacWin) || takeDouble || firstStep) &&
                             !(contactBreak && doubleHold_reg) && !stopNow && !suppress_reg; // RQ2 RQ8
   assign tripleStage_next = (tripleStage_reg || (panelB_reg.triple && eacWin)) &&
                             !(contactBreak && tripleHold_reg) && !stopNow && !suppress_reg; // RQ2 RQ8
   assign doubleHold_next  = (doubleHold_reg || secondStep) && !stopNow && !suppress_reg;
   assign tripleHold_next  = (tripleHold_reg || firstStep) && !stopNow && !suppress_reg;
   assign camDone_next     = camWin && (camDone_reg || clutchSet);
   assign spaces_next      = (clutch_reg && contactMake) ? spaces_reg + 1'b1 : spaces_reg;

   // Latch registers
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         clutch_reg      <= 1'b0;
         suppress_reg    <= 1'b0;
         panelSingle_reg <= 1'b0;
         doubleStage_reg <= 1'b0;
         tripleStage_reg <= 1'b0;
         doubleHold_reg  <= 1'b0;
         tripleHold_reg  <= 1'b0;
         camDone_reg     <= 1'b0;
         stop_reg        <= 1'b0;
         lowSpeed_reg    <= 1'b0;
         spaces_reg      <= `CSC_COUNT_RST;
      end else begin
         clutch_reg      <= clutch_next;
         suppress_reg    <= suppress_next;
         panelSingle_reg <= panelSingle_next;
         doubleStage_reg <= doubleStage_next;
         tripleStage_reg <= tripleStage_next;
         doubleHold_reg  <= doubleHold_next;
         tripleHold_reg  <= tripleHold_next;
         camDone_reg     <= camDone_next;
         stop_reg        <= stopNow; // RQ15
         lowSpeed_reg    <= clutch_next; // RQ14
         spaces_reg      <= spaces_next;
      end
   end

   assign clutchDrive  = clutch_reg; // RQ16
   assign carriageStop = stop_reg;
   assign lowSpeedSel  = lowSpeed_reg;

   // ************************************************************
   // Wishbone slave
   // ************************************************************
   logic        ack_reg;
   logic [31:0] rdat_reg;
   logic [31:0] rdat_next;
   logic        busReq;
   logic        selCtrl;
   logic        selStat;
   logic        selCount;
   logic        ctrlWrite;
   csc_status_t statusWord;

   assign busReq    = wb_cyc_i && wb_stb_i && !ack_reg;
   assign selCtrl   = wb_adr_i == `CSC_ADR_CTRL;
   assign selStat   = wb_adr_i == `CSC_ADR_STAT;
   assign selCount  = wb_adr_i == `CSC_ADR_COUNT;
   assign ctrlWrite = busReq && wb_we_i && selCtrl && wb_sel_i[0];
   assign ctrl_next = ctrlWrite ? wb_dat_i[`CSC_CTRL_W-1:0] : ctrl_reg;

   // Status word gathers the latch states and index angle
   assign statusWord = '{degree:      degree,
                         tripleHold:  tripleHold_reg,
                         doubleHold:  doubleHold_reg,
                         tripleStage: tripleStage_reg,
                         doubleStage: doubleStage_reg,
                         panelSingle: panelSingle_reg,
                         suppress:    suppress_reg,
                         clutch:      clutch_reg};

   // Read multiplexer, unmapped reads return zero
   assign rdat_next = selCtrl  ? {{(32-`CSC_CTRL_W){1'b0}}, ctrl_reg} :
                      selStat  ? {{(32-$bits(csc_status_t)){1'b0}}, statusWord} :
                      selCount ? {{(32-`CSC_COUNT_W){1'b0}}, spaces_reg} : 32'h0000_0000;

   // Bus registers, answer one cycle after the request
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         ctrl_reg <= `CSC_CTRL_RST;
         ack_reg  <= 1'b0;
         rdat_reg <= 32'h0000_0000;
      end else begin
         ctrl_reg <= ctrl_next;
         ack_reg  <= busReq;
         rdat_reg <= busReq ? rdat_next : rdat_reg;
      end
   end

   assign wb_ack_o = ack_reg;
   assign wb_dat_o = rdat_reg;

   // ************************************************************
   // Assertions
   // ************************************************************
   default clocking cb @(posedge clk); endclocking
   default disable iff (sys_rst);

   a_stop_drops_clutch: assert property ( // RQ15
      stopNow |=> !clutchDrive && carriageStop && !panelSingle_reg)
      else $error("clutch held after stop");

   a_triple_first_make: assert property ( // RQ1
      firstStep |=> !carriageStop && clutchDrive && tripleHold_reg && doubleStage_reg)
      else $error("triple stopped on first make");

   a_triple_break_release: assert property ( // RQ2
      contactBreak && tripleHold_reg && !stopNow |=> !tripleStage_reg)
      else $error("triple stage not released on break");

   a_panel_over_internal: assert property ( // RQ3
      clutchSet && panelSingle_reg && !doubleStage_reg |=> !doubleStage_reg)
      else $error("internal double taken over panel single");

   a_multi_opens_single: assert property ( // RQ4
      clutch_reg && contactMake && doubleStage_reg && !doubleHold_reg && !panelSingle_reg
      |=> !carriageStop && clutchDrive)
      else $error("double stopped on first make");

   a_single_bypass: assert property ( // RQ5
      clutch_reg && contactMake && panelSingle_reg && !tripleStage_reg |=> carriageStop && !clutchDrive)
      else $error("panel single did not stop on first make");

   a_suppress_blocks: assert property ( // RQ7
      suppress_reg && !clutchDrive |=> !clutchDrive)
      else $error("clutch set while suppressed");

   a_suppress_cancels: assert property ( // RQ8
      suppress_reg && !clutch_reg |=> !doubleStage_reg && !tripleStage_reg)
      else $error("multi-line space survived suppression");

   a_clutch_from_cam: assert property ( // RQ16
      $rose(clutchDrive) |-> $past(camWin) && $past(runOn))
      else $error("clutch set outside cam window");

   a_low_speed: assert property ( // RQ14
      clutchDrive |-> lowSpeedSel)
      else $error("spacing without low speed");

   // Once per cam window, and only for a held, unsuppressed request
   a_cam_once: assert property ( // RQ16
      camDone_reg && !clutchDrive |=> !clutchDrive)
      else $error("clutch set twice in one cam window");

   a_clutch_needs_req: assert property ( // RQ9
      $rose(clutchDrive) |-> $past(anyRequest) && !$past(suppress_reg))
      else $error("clutch set without a space request");

   a_first_card_double: assert property ( // RQ11
      clutchSet && intDouble && !panelSingle_reg && !tripleStage_reg |=> doubleStage_reg)
      else $error("internal double not taken");

   a_stop_one_cycle: assert property ( // RQ15
      carriageStop |=> !carriageStop)
      else $error("stop pulse longer than one cycle");

   c_single_space: cover property (
      clutchSet && panelSingle_reg ##[1:300] carriageStop);
   c_triple_space: cover property (
      firstStep ##[1:1000] secondStep ##[1:1000] stopNow);
   c_suppressed: cover property (
      suppress_reg && camWin && anyRequest);
   c_bus_write: cover property (
      ctrlWrite ##1 wb_ack_o);
   c_first_card: cover property (
      takeDouble ##[1:1000] secondStep);

endmodule
`default_nettype wire

/* rtl/csc_defs.svh */
// Constants for the carriage space control block
`ifndef CSC_DEFS_SVH
`define CSC_DEFS_SVH

// ************************************************************
// Timing of the machine-cycle index
// ************************************************************
`define CSC_CLK_HZ        64'd40000000
`define CSC_SEC_PER_MIN   64'd60
`define CSC_DEG_PER_REV   64'd360
`define CSC_RATE_LOW_CPM  64'd100
`define CSC_RATE_HIGH_CPM 64'd150
`define CSC_DIV_W         17
`define CSC_DEG_W         9
`define CSC_DEG_LAST      9'h167
`define CSC_DEG_ZERO      9'h000

// ************************************************************
// Cam and contact windows in degrees
// ************************************************************
`define CSC_CAM_END       9'h00F
`define CSC_EAC_START     9'h159
`define CSC_SUPP_END      9'h01E

// ************************************************************
// Register map
// ************************************************************
`define CSC_ADR_W         8
`define CSC_ADR_CTRL      8'h00
`define CSC_ADR_STAT      8'h04
`define CSC_ADR_COUNT     8'h08
`define CSC_CTRL_W        3
`define CSC_CTRL_RST      3'h5
`define CSC_CTRL_LIST     0
`define CSC_CTRL_RATE     1
`define CSC_CTRL_RUN      2
`define CSC_COUNT_W       8
`define CSC_COUNT_RST     8'h00

`endif

/* rtl/csc_pkg.sv */
// Types shared by the carriage space control files
package csc_pkg;

   // Panel space impulses
   typedef struct packed {
      logic single;
      logic dbl;
      logic triple;
      logic suppress;
   } csc_panel_t;

   // Cycle-type indications
   typedef struct packed {
      logic detail;
      logic minorTotal;
      logic interTotal;
      logic majorTotal;
      logic firstCard;
   } csc_cycle_t;

   // Machine printing rate
   typedef enum logic {
      CSC_RATE_100 = 1'b0,
      CSC_RATE_150 = 1'b1
   } csc_rate_t;

   // Status word layout
   typedef struct packed {
      logic [8:0] degree;
      logic       tripleHold;
      logic       doubleHold;
      logic       tripleStage;
      logic       doubleStage;
      logic       panelSingle;
      logic       suppress;
      logic       clutch;
   } csc_status_t;

endpackage

/* rtl/csc_cycle_index.sv */
// Machine-cycle degree counter
`timescale 1ns/10ps
`default_nettype none
`include "csc_defs.svh"

module csc_cycle_index #(
   parameter int unsigned DIV_100 = 1,
   parameter int unsigned DIV_150 = 1
) (
   input  wire logic                  clk,      // System clock
   input  wire logic                  sys_rst,  // Synchronous reset
   input  wire logic                  runEn,    // Index turning
   input  wire csc_pkg::csc_rate_t    rateSel,  // Printing rate
   output logic [`CSC_DEG_W-1:0]      degree,   // Index angle
   output logic                       degTick   // Degree advance pulse
);
   import csc_pkg::*;

   logic [`CSC_DIV_W-1:0] divCnt_reg;
   logic [`CSC_DIV_W-1:0] divCnt_next;
   logic [`CSC_DEG_W-1:0] degree_reg;
   logic [`CSC_DEG_W-1:0] degree_next;
   logic [`CSC_DIV_W-1:0] divLast;
   logic                  wrapDiv;

   // Divider limit follows the selected rate
   assign divLast     = (rateSel == CSC_RATE_150) ? `CSC_DIV_W'(DIV_150 - 1) : `CSC_DIV_W'(DIV_100 - 1);
   assign wrapDiv     = runEn && (divCnt_reg >= divLast);
   assign divCnt_next = !runEn ? divCnt_reg : (wrapDiv ? '0 : divCnt_reg + 1'b1);
   assign degree_next = !wrapDiv ? degree_reg :
                        ((degree_reg == `CSC_DEG_LAST) ? `CSC_DEG_ZERO : degree_reg + 1'b1);

   // Counter registers
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         divCnt_reg <= '0;
         degree_reg <= `CSC_DEG_ZERO;
      end else begin
         divCnt_reg <= divCnt_next;
         degree_reg <= degree_next;
      end
   end

   assign degree  = degree_reg;
   assign degTick = wrapDiv;

endmodule
`default_nettype wire

/* sim/csc_carriage_model.sv */
// Behavioural carriage: clutch-driven line-space contact
`timescale 1ns/10ps
`default_nettype none

module csc_carriage_model (
   input  wire logic       clk,          // System clock
   input  wire logic       sys_rst,      // Synchronous reset
   input  wire logic       clutchDrive,  // Clutch magnet from block
   input  wire logic [7:0] gap,          // One less than the clocks per contact half-step
   output logic            lineContact   // Line-space contact, high = made
);
   logic [7:0] phaseCnt;

   // ************************************************************
   // Contact timing
   // ************************************************************
   // Platen turns only while clutched; contact rests open otherwise
   always_ff @(posedge clk) begin
      if (sys_rst || !clutchDrive) begin
         phaseCnt    <= 8'h00;
         lineContact <= 1'b0;
      end else if (phaseCnt == gap) begin
         phaseCnt    <= 8'h00;
         lineContact <= ~lineContact;  // Break always separates makes
      end else begin
         phaseCnt <= phaseCnt + 8'h01;
      end
   end
endmodule
`default_nettype wire

/* sim/carriage_space_control_tb_top.sv */
// Self-checking bench for carriage space control
`timescale 1ns/10ps
`default_nettype none
`include "csc_defs.svh"

module carriage_space_control_tb_top;
   import csc_pkg::*;

   logic        clk = 1'b0;
   logic        sys_rst = 1'b1;
   logic        wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
   logic [7:0]  wb_adr_i = 8'h00;
   logic [3:0]  wb_sel_i = 4'h0;
   logic [31:0] wb_dat_i = 32'h0, wb_dat_o;
   logic        wb_ack_o;
   csc_panel_t  panelPulse = '0;
   csc_cycle_t  cycleType = '0;
   logic        lineContact, clutchDrive, carriageStop, lowSpeedSel;
   logic [7:0]  gap = 8'h06;
   logic        prevContact = 1'b0, prevClutch = 1'b0;
   int          errors = 0, nCompared = 0, makes = 0, stops = 0, rises = 0;
   logic [31:0] q;

   // ************************************************************
   // Clock, design and carriage
   // ************************************************************
   always #12.5 clk = ~clk;

   carriage_space_control #(.DEG_CYC_100(4), .DEG_CYC_150(3)) u_dut (
      .clk(clk), .sys_rst(sys_rst), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
      .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
      .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .panelPulse(panelPulse), .cycleType(cycleType),
      .lineContact(lineContact), .clutchDrive(clutchDrive), .carriageStop(carriageStop),
      .lowSpeedSel(lowSpeedSel));

   csc_carriage_model u_carriage (
      .clk(clk), .sys_rst(sys_rst), .clutchDrive(clutchDrive), .gap(gap), .lineContact(lineContact));

   // ************************************************************
   // Checking and bus tasks
   // ************************************************************
   task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
      nCompared++;
      if (seen !== exp) begin
         errors++;
         $display("BAD %s expected %0h seen %0h", what, exp, seen);
      end
   endtask

   // One classic cycle; held until ack is sampled high
   task automatic wbx(input logic we, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r);
      int n;
      n = 0;
      @(posedge clk);
      wb_cyc_i <= 1'b1;
      wb_stb_i <= 1'b1;
      wb_we_i  <= we;
      wb_adr_i <= a;
      wb_dat_i <= d;
      wb_sel_i <= 4'hF;
      do begin
         @(posedge clk);
         n++;
      end while (wb_ack_o !== 1'b1 && n < 50);
      r = wb_dat_o;
      if (n >= 50) chk("bus ack", 32'h0, 32'h1);
      wb_cyc_i <= 1'b0;
      wb_stb_i <= 1'b0;
      wb_we_i  <= 1'b0;
   endtask

   // Poll the index angle until it falls inside lo..hi
   task automatic wait_deg(input int lo, input int hi);
      int n;
      int d;
      n = 0;
      d = -1;
      while (!(d >= lo && d <= hi) && n < 3000) begin
         wbx(1'b0, `CSC_ADR_STAT, 32'h0, q);
         d = int'(q[15:7]);
         n++;
      end
      if (n >= 3000) chk("index angle", 32'h0, 32'h1);
   endtask

   // One print cycle: pins set in the early window, outcome counted
   task automatic sp(input logic [2:0] ctl, input logic [3:0] pan, input logic [4:0] ct,
                     input int exp, input logic [7:0] g, input string nm);
      logic [31:0] c0;
      wbx(1'b1, `CSC_ADR_CTRL, {29'h0, ctl}, q);
      gap <= g;
      wbx(1'b0, `CSC_ADR_COUNT, 32'h0, c0);
      wait_deg(345, 359);
      makes = 0;
      stops = 0;
      rises = 0;
      panelPulse <= pan;
      cycleType  <= ct;
      wait_deg(16, 40);
      panelPulse <= '0;
      cycleType  <= '0;
      wait_deg(200, 230);
      chk({nm, " makes"}, makes, exp);
      chk({nm, " stops"}, stops, (exp > 0) ? 1 : 0);
      chk({nm, " clutch"}, rises, (exp > 0) ? 1 : 0);
      wbx(1'b0, `CSC_ADR_COUNT, 32'h0, q);
      chk({nm, " count"}, {24'h0, q[7:0] - c0[7:0]}, exp);
      wbx(1'b0, `CSC_ADR_STAT, 32'h0, q);
      chk({nm, " latches"}, {25'h0, q[6:0]}, 32'h0);
      $display("test %s done", nm);
   endtask

   task automatic close_out;
      $display("compared %0d mismatches %0d", nCompared, errors);
      if (errors == 0 && nCompared > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask

   // ************************************************************
   // Pin monitor
   // ************************************************************
   always @(posedge clk) begin
      prevContact <= lineContact;
      prevClutch  <= clutchDrive;
      if (lineContact === 1'b1 && prevContact === 1'b0) makes++;
      if (carriageStop === 1'b1) stops++;
      if (clutchDrive === 1'b1 && prevClutch === 1'b0) begin
         rises++;
         chk("low speed", {31'h0, lowSpeedSel}, 32'h1);
      end
   end

   // ************************************************************
   // Test sequence
   // ************************************************************
   initial begin
      repeat (8) @(posedge clk);
      sys_rst <= 1'b0;
      wbx(1'b0, `CSC_ADR_CTRL, 32'h0, q);
      chk("ctrl reset", q, 32'h5);
      wbx(1'b0, `CSC_ADR_COUNT, 32'h0, q);
      chk("count reset", q, 32'h0);
      wbx(1'b1, `CSC_ADR_STAT, 32'hFFFF, q);
      wbx(1'b0, `CSC_ADR_STAT, 32'h0, q);
      chk("stat read-only", {25'h0, q[6:0]}, 32'h0);
      wbx(1'b1, 8'h0C, 32'hFFFF, q);
      wbx(1'b0, 8'h0C, 32'h0, q);
      chk("unmapped", q, 32'h0);
      $display("test registers done");
      // List on means list tied to every cycle
      sp(3'h5, 4'h0, 5'h10, 1, 8'h06, "detail");
      sp(3'h5, 4'h0, 5'h08, 1, 8'h28, "minor list");
      sp(3'h5, 4'h0, 5'h01, 2, 8'h06, "first card");
      sp(3'h5, 4'h2, 5'h00, 3, 8'h28, "triple");
      sp(3'h5, 4'h4, 5'h10, 2, 8'h06, "double on detail");
      sp(3'h5, 4'h2, 5'h10, 3, 8'h06, "triple on detail");
      sp(3'h5, 4'h8, 5'h01, 1, 8'h28, "single on first");
      sp(3'h5, 4'h2, 5'h01, 3, 8'h06, "triple on first");
      sp(3'h5, 4'h1, 5'h10, 0, 8'h06, "suppress");
      sp(3'h5, 4'h5, 5'h00, 0, 8'h06, "suppress double");
      sp(3'h5, 4'h3, 5'h01, 0, 8'h06, "suppress triple");
      sp(3'h4, 4'h0, 5'h08, 0, 8'h06, "minor group");
      sp(3'h4, 4'h0, 5'h04, 1, 8'h06, "inter group");
      sp(3'h4, 4'h0, 5'h02, 1, 8'h28, "major group");
      sp(3'h4, 4'h0, 5'h01, 2, 8'h06, "first group");
      sp(3'h7, 4'h4, 5'h10, 2, 8'h06, "fast rate");
      close_out();
   end

   // Hang guard, well beyond the expected run
   initial begin
      repeat (90000) @(posedge clk);
      errors++;
      close_out();
   end
endmodule
`default_nettype wire
